// *** hdl/flash_hw_if_map.sv ***
// address decoder for the flash sequencer interface and pin monitor register
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - decode one command word at FFA20000
// - firmware store 4 KB at 00017000
// - sequencer RAM/ROM 4 KB, read-only on ROM
// - configuration area 80 bytes decoded
// - OTP setting area 96 bytes decoded
// - pin monitor read-only, byte reads only
// - bit 7 follows the flash mode pin
// - write enable bit gates code P/E entry
// - reserved monitor bits read zero
// - ROM variant discards sequencer RAM window writes silently
module flash_hw_if_map
   import flash_map_pkg::*;
#(
   parameter bit ROM_VARIANT = 1'b0
)(
   input  wire logic           sys_clk,
   input  wire logic           rst_b,
   input  wire bus_req_type    bus_req,
   input  wire logic           firmware_area_select_bit,
   input  wire logic           flash_mode_pin,
   input  wire logic           pe_entry_request,
   input  wire logic [31:0]    window_rdata,
   output var  logic [31:0]    bus_rdata,
   output var  logic           bus_ack,
   output var  logic           bus_error,
   output var  logic           cmd_valid,
   output var  logic [31:0]    cmd_data,
   output var  window_req_type fw_store_req,
   output var  window_req_type seq_ram_req,
   output var  window_req_type cfg_area_req,
   output var  window_req_type otp_area_req,
   output var  logic           pe_entry_grant,
   output var  logic           pe_entry_refused
);
   logic       pin_level;
   logic [7:0] flash_pin_monitor;
   region_type region;
   logic       protected_area;
   logic       read_blocked;
   logic       width_bad;

   function automatic logic in_range(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic window_req_type make_req(input logic        sel,
                                               input bus_req_type r,
                                               input logic [31:0] base);
      // local result: a dotted function name would resolve to the sel argument
      window_req_type v;
      v.sel    = sel;
      v.write  = r.write;
      v.offset = r.addr - base;
      v.wdata  = r.wdata;
      return v;
   endfunction : make_req

   pin_sync u_pin_sync (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .pin_in  (flash_mode_pin),
      .level   (pin_level)
   );

   // monitor register is not stored: bit 7 tracks the pin, rest are zero
   always_comb begin
      flash_pin_monitor                 = PIN_MONITOR_RESET;
      flash_pin_monitor[WE_MONITOR_BIT] = pin_level;
   end

   always_comb begin
      region = REGION_NONE;
      if (bus_req.addr[31:2] == CMD_ISSUE_ADDR[31:2]) begin
         region = REGION_CMD_ISSUE;
      end else if (in_range(bus_req.addr, FW_STORE_LO, FW_STORE_HI)) begin
         region = REGION_FW_STORE;
      end else if (in_range(bus_req.addr, SEQ_RAM_LO, SEQ_RAM_HI)) begin
         region = REGION_SEQ_RAM;
      end else if (in_range(bus_req.addr, CFG_AREA_LO, CFG_AREA_HI)) begin
         region = REGION_CFG_AREA;
      end else if (in_range(bus_req.addr, OTP_AREA_LO, OTP_AREA_HI)) begin
         region = REGION_OTP_AREA;
      end else if (bus_req.addr == PIN_MONITOR_ADDR) begin
         region = REGION_PIN_MONITOR;
      end
   end

   assign protected_area = (region == REGION_FW_STORE) || (region == REGION_CFG_AREA)
                           || (region == REGION_OTP_AREA);
   // reads of protected areas are only exposed while the select bit is set
   assign read_blocked   = protected_area && !bus_req.write && !firmware_area_select_bit;
   assign width_bad      = (region == REGION_PIN_MONITOR)
                           && (bus_req.write || bus_req.size != SIZE_BYTE);

   // window strobes are one-cycle pulses, registered like every output
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fw_store_req <= '0;
         seq_ram_req  <= '0;
         cfg_area_req <= '0;
         otp_area_req <= '0;
      end else begin
         fw_store_req <= make_req(bus_req.valid && region == REGION_FW_STORE
                                  && !read_blocked, bus_req, FW_STORE_LO);
         // ROM variant drops writes to the window, no error raised
         seq_ram_req  <= make_req(bus_req.valid && region == REGION_SEQ_RAM
                                  && !(ROM_VARIANT && bus_req.write),
                                  bus_req, SEQ_RAM_LO);
         cfg_area_req <= make_req(bus_req.valid && region == REGION_CFG_AREA
                                  && !read_blocked, bus_req, CFG_AREA_LO);
         otp_area_req <= make_req(bus_req.valid && region == REGION_OTP_AREA
                                  && !read_blocked, bus_req, OTP_AREA_LO);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_valid <= 1'b0;
         cmd_data  <= '0;
      end else begin
         cmd_valid <= bus_req.valid && bus_req.write && region == REGION_CMD_ISSUE;
         if (bus_req.valid && bus_req.write && region == REGION_CMD_ISSUE) begin
            cmd_data <= bus_req.wdata;
         end
      end
   end

   // answer one cycle after the request; window data is captured in the request cycle and returned with ack
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_ack   <= 1'b0;
         bus_error <= 1'b0;
         bus_rdata <= '0;
      end else begin
         bus_ack   <= bus_req.valid;
         bus_error <= bus_req.valid && (region == REGION_NONE || width_bad);
         bus_rdata <= '0;
         if (bus_req.valid && !bus_req.write) begin
            case (region)
               REGION_PIN_MONITOR: begin
                  if (!width_bad) begin
                     bus_rdata <= {24'h000000, flash_pin_monitor};
                  end
               end
               REGION_FW_STORE, REGION_CFG_AREA, REGION_OTP_AREA: begin
                  if (!read_blocked) begin
                     bus_rdata <= window_rdata;
                  end
               end
               REGION_SEQ_RAM: begin
                  bus_rdata <= window_rdata;
               end
               default: begin
                  bus_rdata <= '0;
               end
            endcase
         end
      end
   end

   // code P/E entry allowed only while the pin reads as enabled
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pe_entry_grant   <= 1'b0;
         pe_entry_refused <= 1'b0;
      end else begin
         pe_entry_grant   <= pe_entry_request && flash_pin_monitor[WE_MONITOR_BIT];
         pe_entry_refused <= pe_entry_request && !flash_pin_monitor[WE_MONITOR_BIT];
      end
   end
endmodule : flash_hw_if_map
`default_nettype wire

// *** hdl/pin_sync.sv ***
// three-stage synchroniser for the flash mode pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync
   import flash_map_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic pin_in,
   output var  logic level
);
   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // change accepted only once the two later stages agree
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         level <= 1'b0;
      end else if (stage2 == stage3) begin
         level <= stage3;
      end
   end
endmodule : pin_sync
`default_nettype wire

// *** include/flash_map_pkg.sv ***
// package: address windows, pin monitor layout and bus carrier types
package flash_map_pkg;
   localparam logic [31:0] CMD_ISSUE_ADDR   = 32'hFFA20000;
   localparam logic [31:0] FW_STORE_LO      = 32'h00017000;
   localparam logic [31:0] FW_STORE_HI      = 32'h00017FFF;
   localparam logic [31:0] SEQ_RAM_LO       = 32'hFFA12000;
   localparam logic [31:0] SEQ_RAM_HI       = 32'hFFA12FFF;
   localparam logic [31:0] CFG_AREA_LO      = 32'hFF300040;
   localparam logic [31:0] CFG_AREA_HI      = 32'hFF30008F;
   localparam logic [31:0] OTP_AREA_LO      = 32'hFF380040;
   localparam logic [31:0] OTP_AREA_HI      = 32'hFF38009F;
   localparam logic [31:0] PIN_MONITOR_ADDR = 32'hFFA10000;
   localparam int          WE_MONITOR_BIT   = 7;
   localparam logic [7:0]  PIN_MONITOR_RESET = 8'h00;
   localparam logic [1:0]  SIZE_BYTE        = 2'h0;
   localparam logic [1:0]  SIZE_HALF        = 2'h1;
   localparam logic [1:0]  SIZE_WORD        = 2'h2;

   typedef enum logic [2:0] {
      REGION_NONE,
      REGION_CMD_ISSUE,
      REGION_FW_STORE,
      REGION_SEQ_RAM,
      REGION_CFG_AREA,
      REGION_OTP_AREA,
      REGION_PIN_MONITOR
   } region_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic        sel;
      logic        write;
      logic [31:0] offset;
      logic [31:0] wdata;
   } window_req_type;
endpackage : flash_map_pkg

// *** testbench/flash_hw_if_map_sva.sv ***
// checker: decode and pin monitor properties
`timescale 1ns/100ps
`default_nettype none
module flash_hw_if_map_sva
   import flash_map_pkg::*;
#(
   parameter bit ROM_VARIANT = 1'b0
)(
   input wire logic           sys_clk,
   input wire logic           rst_b,
   input wire bus_req_type    bus_req,
   input wire logic           firmware_area_select_bit,
   input wire logic           pe_entry_request,
   input wire logic [31:0]    bus_rdata,
   input wire logic           bus_ack,
   input wire logic           bus_error,
   input wire logic           cmd_valid,
   input wire window_req_type fw_store_req,
   input wire window_req_type seq_ram_req,
   input wire logic           pe_entry_grant,
   input wire logic           pe_entry_refused
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire logic [31:0] a = bus_req.addr;
   wire logic rd = bus_req.valid && !bus_req.write;
   wire logic fw = rd && a >= FW_STORE_LO && a <= FW_STORE_HI;
   wire logic pm = bus_req.valid && a == PIN_MONITOR_ADDR;
   a_ack_follows: assert property (bus_req.valid |=> bus_ack) else $error("no ack");
   a_cmd_pulse: assert property (bus_req.valid && bus_req.write
      && a == CMD_ISSUE_ADDR |=> cmd_valid) else $error("no command");
   a_fw_guard: assert property (fw && !firmware_area_select_bit
      |=> !fw_store_req.sel && bus_rdata == 32'h0) else $error("guard");
   a_fw_offset: assert property (fw && firmware_area_select_bit
      |=> fw_store_req.sel && fw_store_req.offset == $past(a) - FW_STORE_LO) else $error("fw");
   a_seq_offset: assert property (rd && a >= SEQ_RAM_LO && a <= SEQ_RAM_HI
      |=> seq_ram_req.sel && seq_ram_req.offset == $past(a) - SEQ_RAM_LO) else $error("seq");
   a_monitor_width: assert property (pm
      && (bus_req.write || bus_req.size != SIZE_BYTE)
      |=> bus_error && bus_rdata == 32'h0) else $error("width");
   a_reserved_zero: assert property (pm && rd && bus_req.size == SIZE_BYTE
      |=> !bus_error && bus_rdata[31:8] == 24'h0 && bus_rdata[6:0] == 7'h0)
      else $error("reserved");
   a_entry_gate: assert property (pe_entry_request
      |=> pe_entry_grant != pe_entry_refused) else $error("entry");
   a_rom_discard: assert property (bus_req.valid && bus_req.write
      && a >= SEQ_RAM_LO && a <= SEQ_RAM_HI
      |=> seq_ram_req.sel == !ROM_VARIANT && bus_ack && !bus_error) else $error("rom write");
endmodule : flash_hw_if_map_sva
bind flash_hw_if_map flash_hw_if_map_sva #(.ROM_VARIANT(ROM_VARIANT))
   u_flash_hw_if_map_sva (.sys_clk(sys_clk),
   .rst_b(rst_b), .bus_req(bus_req), .firmware_area_select_bit(firmware_area_select_bit),
   .pe_entry_request(pe_entry_request), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
   .bus_error(bus_error), .cmd_valid(cmd_valid), .fw_store_req(fw_store_req),
   .seq_ram_req(seq_ram_req), .pe_entry_grant(pe_entry_grant),
   .pe_entry_refused(pe_entry_refused));
`default_nettype wire

// *** testbench/flash_hw_if_map_test.sv ***
// testbench: address decode, pin monitor and entry gating
`timescale 1ns/100ps
`default_nettype none
module flash_hw_if_map_test
   import flash_map_pkg::*;
;
   bus_req_type    req;
   window_req_type fw, sr, cf, ot, rsr;
   logic           rack, rerr;
   logic [31:0]    off;
   logic [31:0]    lo_addr [4] = '{FW_STORE_LO, SEQ_RAM_LO, CFG_AREA_LO, OTP_AREA_LO};
   logic           sys_clk = 1'h0;
   logic           rst_b, fsel, pin, pe_req, ack, err, cv, gnt, rfs;
   logic [31:0]    wrd, rdata, cmd;
   int             n_fail, check_count, cyc;
   logic [31:0]    hi_addr [4] = '{FW_STORE_HI, SEQ_RAM_HI, CFG_AREA_HI, OTP_AREA_HI};
   flash_hw_if_map u_flash_hw_if_map (.sys_clk(sys_clk), .rst_b(rst_b), .bus_req(req),
      .firmware_area_select_bit(fsel), .flash_mode_pin(pin), .pe_entry_request(pe_req),
      .window_rdata(wrd), .bus_rdata(rdata), .bus_ack(ack), .bus_error(err),
      .cmd_valid(cv), .cmd_data(cmd), .fw_store_req(fw), .seq_ram_req(sr),
      .cfg_area_req(cf), .otp_area_req(ot), .pe_entry_grant(gnt), .pe_entry_refused(rfs));
   // ROM build: sequencer RAM window writes must be dropped without an error
   flash_hw_if_map #(.ROM_VARIANT(1'b1)) u_flash_hw_if_map_rom (.sys_clk(sys_clk),
      .rst_b(rst_b), .bus_req(req), .firmware_area_select_bit(fsel),
      .flash_mode_pin(pin), .pe_entry_request(pe_req), .window_rdata(wrd),
      .bus_rdata(), .bus_ack(rack), .bus_error(rerr), .cmd_valid(), .cmd_data(),
      .fw_store_req(), .seq_ram_req(rsr), .cfg_area_req(), .otp_area_req(),
      .pe_entry_grant(), .pe_entry_refused());
   always #4 sys_clk = ~sys_clk;
   // ceiling well above the sixty or so cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (n_fail == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask : chk
   task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] ad,
                      input logic [31:0] wd, input logic [31:0] er, input logic ee);
      @(negedge sys_clk);
      req = '{1'h1, w, sz, ad, wd};
      @(negedge sys_clk);
      req.valid = 1'h0;
      chk("ack", {31'h0, ack}, 32'h1);
      chk("error", {31'h0, err}, {31'h0, ee});
      chk("rdata", rdata, er);
   endtask : acc
   // pin passes a synchroniser, so let it settle before reading
   task automatic pe(input logic lvl);
      pin = lvl;
      repeat (8) @(negedge sys_clk);
      acc(1'h0, SIZE_BYTE, PIN_MONITOR_ADDR, 32'h0, {24'h0, lvl, 7'h0}, 1'h0);
      pe_req = 1'h1;
      @(negedge sys_clk);
      pe_req = 1'h0;
      chk("entry", {30'h0, gnt, rfs}, {30'h0, lvl, ~lvl});
   endtask : pe
   initial begin
      req = '0;
      rst_b = 1'h0;
      fsel = 1'h0;
      pin = 1'h1;
      pe_req = 1'h0;
      wrd = 32'hA5C33C5A;
      repeat (6) @(negedge sys_clk);
      rst_b = 1'h1;
      pe(1'h1);
      pe(1'h0);
      acc(1'h1, SIZE_BYTE, PIN_MONITOR_ADDR, 32'h0, 32'h0, 1'h1);
      acc(1'h0, SIZE_HALF, PIN_MONITOR_ADDR, 32'h0, 32'h0, 1'h1);
      acc(1'h1, SIZE_WORD, CMD_ISSUE_ADDR, 32'h1234ABCD, 32'h0, 1'h0);
      chk("cmd_valid", {31'h0, cv}, 32'h1);
      chk("cmd", cmd, 32'h1234ABCD);
      acc(1'h0, SIZE_BYTE, CFG_AREA_HI + 32'h1, 32'h0, 32'h0, 1'h1);
      acc(1'h0, SIZE_BYTE, FW_STORE_LO - 32'h1, 32'h0, 32'h0, 1'h1);
      for (int s = 0; s < 2; s++) begin
         fsel = s[0];
         for (int i = 0; i < 4; i++) begin
            acc(1'h0, SIZE_WORD, hi_addr[i], 32'h0, (s || i == 1) ? wrd : 32'h0, 1'h0);
            chk("sel", {28'h0, fw.sel, sr.sel, cf.sel, ot.sel},
                (s || i == 1) ? 32'h8 >> i : 32'h0);
            off = (i == 0) ? fw.offset : (i == 1) ? sr.offset
                : (i == 2) ? cf.offset : ot.offset;
            chk("offset", off, hi_addr[i] - lo_addr[i]);
         end
      end
      acc(1'h1, SIZE_WORD, SEQ_RAM_LO, 32'h5AA5C33C, 32'h0, 1'h0);
      chk("ram write", {30'h0, sr.sel, sr.write}, 32'h3);
      chk("ram wdata", sr.wdata, 32'h5AA5C33C);
      chk("rom answer", {30'h0, rack, rerr}, 32'h2);
      chk("rom sel", {31'h0, rsr.sel}, 32'h0);
      end_sim();
   end
endmodule : flash_hw_if_map_test
`default_nettype wire
